//--- core/tx_cw_pkg.sv
// shared constants for the control word field inserter
package tx_cw_pkg;
  // register byte offsets
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] MULTI_USE_OFS = 6'h04;
  localparam logic [5:0] BUCKET_OFS = 6'h08;
  localparam logic [5:0] PERIOD_OFS = 6'h0c;
  localparam logic [5:0] HEALTH_OFS = 6'h10;
  localparam logic [5:0] STATUS_OFS = 6'h14;
  // control register fields
  localparam int PATH_ON_BIT = 0;
  localparam int SHAPER_ON_BIT = 1;
  // bucket register fields
  localparam int CAPACITY_LSB = 0;
  localparam int REFILL_LSB = 16;
  // health register fields
  localparam int LANE_HEALTH_LSB = 0;
  localparam int INTF_HEALTH_BIT = 16;
  // status register fields
  localparam int TOKENS_LSB = 0;
  localparam int GROUP_LSB = 16;
  // control word layout
  localparam int CAL_START_BIT = 56;
  localparam int CAL_FIELD_MSB = 55;
  localparam int MULTI_USE_LSB = 24;
  // diagnostic word layout
  localparam int DIAG_LANE_BIT = 33;
  localparam int DIAG_INTF_BIT = 32;
  // calendar geometry
  localparam int CAL_ENTRIES = 256;
  localparam int CAL_PER_WORD = 16;
  localparam int CAL_GROUPS = CAL_ENTRIES / CAL_PER_WORD;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] MULTI_USE_RST = 8'h00;
  localparam logic [11:0] CAPACITY_RST = 12'h000;
  localparam logic [11:0] REFILL_RST = 12'h000;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [11:0] LANE_HEALTH_RST = 12'h000;
endpackage : tx_cw_pkg

//--- core/tx_control_word_fields.sv
// control word calendar, multi-use, diagnostic status and token shaper
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - calendar bit one means xon, zero means xoff, sent as is.
// - calendar entries ride in control word bits 55 down to 40.
// - calendar has 256 positions, cycled through over successive control words.
// - word with bit 56 set carries the first sixteen calendar entries.
// - bit 55 holds the lowest-numbered entry of the group, descending.
// - each following control word carries the next sixteen entries.
// - multi-use setting is copied into control word bits 31 to 24.
// - shaper active when its enable is one, bypassed when zero.
// - bucket capacity is a 12-bit token count, one token per byte.
// - each refill adds the 12-bit refill amount to the bucket.
// - 8-bit period counts clock cycles between refills.
// - each lane health bit goes to bit 33 of that lane's diagnostic word.
// - interface health bit goes to bit 32 of every diagnostic word.
// - with the path off, no data is granted; only control words go out.
module tx_control_word_fields #(
  parameter int LANES = 12,
  parameter int BYTES_W = 7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [tx_cw_pkg::CAL_ENTRIES-1:0] tx_calendar_status,
  input wire logic cw_slot,
  output logic [63:0] ctl_word,
  output logic ctl_word_valid,
  input wire logic data_req,
  input wire logic [BYTES_W-1:0] data_bytes,
  output logic data_grant,
  output logic [LANES-1:0] diag_bit33,
  output logic [LANES-1:0] diag_bit32
);

  typedef struct packed {
    logic path_on;
    logic shaper_on;
    logic [7:0] multi_use;
    logic [11:0] capacity;
    logic [11:0] refill;
    logic [7:0] period;
    logic [LANES-1:0] lane_health;
    logic intf_health;
    logic [11:0] tokens;
    logic [7:0] period_cnt;
    logic [3:0] group;
    logic [63:0] ctl_word;
    logic ctl_word_valid;
    logic data_grant;
    logic [LANES-1:0] diag_bit33;
    logic [LANES-1:0] diag_bit32;
    logic [31:0] readdata;
    logic waitrequest;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] wdata,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // read view of each mapped register
  function automatic logic [31:0] reg_view(input state_t s, input logic [5:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      tx_cw_pkg::CTRL_OFS:
      begin
        v[tx_cw_pkg::PATH_ON_BIT] = s.path_on;
        v[tx_cw_pkg::SHAPER_ON_BIT] = s.shaper_on;
      end
      tx_cw_pkg::MULTI_USE_OFS:
      begin
        v[7:0] = s.multi_use;
      end
      tx_cw_pkg::BUCKET_OFS:
      begin
        v[tx_cw_pkg::CAPACITY_LSB +: 12] = s.capacity;
        v[tx_cw_pkg::REFILL_LSB +: 12] = s.refill;
      end
      tx_cw_pkg::PERIOD_OFS:
      begin
        v[7:0] = s.period;
      end
      tx_cw_pkg::HEALTH_OFS:
      begin
        v[tx_cw_pkg::LANE_HEALTH_LSB +: LANES] = s.lane_health;
        v[tx_cw_pkg::INTF_HEALTH_BIT] = s.intf_health;
      end
      tx_cw_pkg::STATUS_OFS:
      begin
        v[tx_cw_pkg::TOKENS_LSB +: 12] = s.tokens;
        v[tx_cw_pkg::GROUP_LSB +: 4] = s.group;
      end
      default:
      begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction : reg_view

  logic [31:0] wr_val;
  logic wr_now;
  logic refill_due;
  logic enough;
  logic [12:0] level;
  logic [12:0] level_in;

  always_comb
  begin
    st_nxt = st_r;
    wr_val = 32'h0000_0000;
    wr_now = 1'b0;
    refill_due = 1'b0;
    enough = 1'b0;
    level = 13'h0000;
    level_in = 13'h0000;

    // bus slave: one wait cycle, then the answer edge
    st_nxt.waitrequest = !((avs_read || avs_write) && st_r.waitrequest);
    if (avs_read && st_r.waitrequest)
    begin
      st_nxt.readdata = reg_view(st_r, avs_address);
    end
    wr_now = avs_write && !st_r.waitrequest;
    if (wr_now)
    begin
      wr_val = merge(reg_view(st_r, avs_address), avs_writedata, avs_byteenable);
      case (avs_address)
        tx_cw_pkg::CTRL_OFS:
        begin
          st_nxt.path_on = wr_val[tx_cw_pkg::PATH_ON_BIT];
          st_nxt.shaper_on = wr_val[tx_cw_pkg::SHAPER_ON_BIT];
        end
        tx_cw_pkg::MULTI_USE_OFS:
        begin
          st_nxt.multi_use = wr_val[7:0];
        end
        tx_cw_pkg::BUCKET_OFS:
        begin
          st_nxt.capacity = wr_val[tx_cw_pkg::CAPACITY_LSB +: 12];
          st_nxt.refill = wr_val[tx_cw_pkg::REFILL_LSB +: 12];
        end
        tx_cw_pkg::PERIOD_OFS:
        begin
          st_nxt.period = wr_val[7:0];
        end
        tx_cw_pkg::HEALTH_OFS:
        begin
          st_nxt.lane_health = wr_val[tx_cw_pkg::LANE_HEALTH_LSB +: LANES];
          st_nxt.intf_health = wr_val[tx_cw_pkg::INTF_HEALTH_BIT];
        end
        default:
        begin
          st_nxt.path_on = st_r.path_on;
        end
      endcase
    end

    // control word fields, one group of sixteen per slot
    st_nxt.ctl_word_valid = cw_slot;
    if (cw_slot)
    begin
      st_nxt.ctl_word = 64'h0000_0000_0000_0000;
      st_nxt.ctl_word[tx_cw_pkg::CAL_START_BIT] = (st_r.group == 4'h0);
      for (int k = 0; k < tx_cw_pkg::CAL_PER_WORD; k++)
      begin
        // status bit copied as is: one is xon, zero is xoff
        st_nxt.ctl_word[tx_cw_pkg::CAL_FIELD_MSB - k] =
          tx_calendar_status[{st_r.group, 4'h0} + 8'(k)];
      end
      st_nxt.ctl_word[tx_cw_pkg::MULTI_USE_LSB +: 8] = st_r.multi_use;
      // 4-bit group wraps after the last of sixteen groups
      st_nxt.group = st_r.group + 4'h1;
    end

    // diagnostic word status bits per lane
    st_nxt.diag_bit33 = st_r.lane_health;
    st_nxt.diag_bit32 = {LANES{st_r.intf_health}};

    // refill timer: period counts cycles between additions
    if (st_r.period_cnt >= st_r.period)
    begin
      refill_due = 1'b1;
      st_nxt.period_cnt = 8'h00;
    end
    else
    begin
      st_nxt.period_cnt = st_r.period_cnt + 8'h01;
    end

    // grant lasts one cycle; the registered grant blocks another in the next cycle only
    enough = !st_r.shaper_on || ({5'h00, st_r.tokens} >= {6'h00, data_bytes});
    st_nxt.data_grant = st_r.path_on && data_req && !st_r.data_grant && enough;

    level = {1'b0, st_r.tokens};
    if (st_nxt.data_grant && st_r.shaper_on)
    begin
      level = level - {6'h00, data_bytes};
    end
    if (refill_due)
    begin
      level_in = level + {1'b0, st_r.refill};
    end
    else
    begin
      level_in = level;
    end
    if (level_in > {1'b0, st_r.capacity})
    begin
      level_in = {1'b0, st_r.capacity};
    end
    st_nxt.tokens = level_in[11:0];
    if (!st_r.shaper_on)
    begin
      // bypassed: bucket starts full when the shaper is switched on
      st_nxt.tokens = st_r.capacity;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.path_on <= tx_cw_pkg::CTRL_RST[tx_cw_pkg::PATH_ON_BIT];
      st_r.shaper_on <= tx_cw_pkg::CTRL_RST[tx_cw_pkg::SHAPER_ON_BIT];
      st_r.multi_use <= tx_cw_pkg::MULTI_USE_RST;
      st_r.capacity <= tx_cw_pkg::CAPACITY_RST;
      st_r.refill <= tx_cw_pkg::REFILL_RST;
      st_r.period <= tx_cw_pkg::PERIOD_RST;
      st_r.lane_health <= LANES'(tx_cw_pkg::LANE_HEALTH_RST);
      st_r.waitrequest <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.readdata;
  assign avs_waitrequest = st_r.waitrequest;
  assign ctl_word = st_r.ctl_word;
  assign ctl_word_valid = st_r.ctl_word_valid;
  assign data_grant = st_r.data_grant;
  assign diag_bit33 = st_r.diag_bit33;
  assign diag_bit32 = st_r.diag_bit32;

endmodule : tx_control_word_fields
`default_nettype wire

//--- bench/tx_control_word_fields_sva.sv
// port-level checks for the control word field inserter
`timescale 1ns/1ns
`default_nettype none
module tx_control_word_fields_chk #(
  parameter int LANES = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [255:0] tx_calendar_status,
  input wire logic cw_slot,
  input wire logic [63:0] ctl_word,
  input wire logic ctl_word_valid,
  input wire logic data_req,
  input wire logic data_grant,
  input wire logic [LANES-1:0] diag_bit32
);
  logic [3:0] grp_r;
  logic [255:0] cal_r;
  logic [15:0] exp_f;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk)
  begin
    grp_r <= !rst_n ? 4'h0 : grp_r + {3'h0, ctl_word_valid};
    cal_r <= cw_slot ? tx_calendar_status : cal_r;
  end
  always_comb
  begin
    for (int i = 0; i < 16; i++) exp_f[15-i] = cal_r[{grp_r, 4'h0}+i];
  end
  cw_answer_a: assert property (cw_slot |=> ctl_word_valid) else $error("no word after slot");
  cw_cause_a: assert property (ctl_word_valid |-> $past(cw_slot)) else $error("word without slot");
  cw_fields_a: assert property (ctl_word_valid |-> ctl_word[56:40] == {grp_r == 4'h0, exp_f})
    else $error("calendar field wrong");
  cw_spare_a: assert property (ctl_word_valid |-> ctl_word[39:32] == 8'h00 && ctl_word[23:0] == 24'h0)
    else $error("spare bits set");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  bus_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("bus answer too long");
  grant_pulse_a: assert property (data_grant |-> $past(data_req) ##1 !data_grant) else $error("grant misshaped");
  intf_copy_a: assert property (diag_bit32 == '0 || diag_bit32 == '1) else $error("interface bit differs");
endmodule : tx_control_word_fields_chk
bind tx_control_word_fields tx_control_word_fields_chk #(.LANES(LANES)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .tx_calendar_status(tx_calendar_status), .cw_slot(cw_slot), .ctl_word(ctl_word),
  .ctl_word_valid(ctl_word_valid), .data_req(data_req), .data_grant(data_grant), .diag_bit32(diag_bit32));
`default_nettype wire

//--- bench/peer_receiver.sv
// peer receiver model rebuilding the calendar from control words
`timescale 1ns/1ns
`default_nettype none
module peer_receiver (
  input wire logic sys_clk,
  input wire logic ctl_word_valid,
  input wire logic [63:0] ctl_word,
  output logic [255:0] rx_cal,
  output logic [7:0] rx_mu
);
  logic [3:0] g;
  initial rx_cal = '0;
  initial g = 4'h0;
  always @(posedge sys_clk)
  begin
    if (ctl_word_valid)
    begin
      // start bit realigns, otherwise next group follows
      if (ctl_word[56]) g = 4'h0;
      for (int i = 0; i < 16; i++) rx_cal[{g, 4'h0}+i] <= ctl_word[55-i];
      g = g + 4'h1;
      rx_mu <= ctl_word[31:24];
    end
  end
endmodule : peer_receiver
`default_nettype wire

//--- bench/tx_control_word_fields_tb.sv
// self-checking bench for the control word field inserter
`timescale 1ns/1ns
`default_nettype none
module tx_control_word_fields_tb;
  logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, cw_slot = 0, data_req = 0;
  logic [5:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, seed = 32'hdfcd, q, h;
  logic [255:0] cal = '0, rx_cal;
  logic [6:0] data_bytes = '0;
  logic [7:0] mu, rx_mu;
  logic [63:0] ctl_word;
  logic [11:0] diag_bit33, diag_bit32;
  logic avs_waitrequest, ctl_word_valid, data_grant;
  int fails = 0, checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  tx_control_word_fields DUT (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_calendar_status(cal), .cw_slot(cw_slot), .ctl_word(ctl_word),
    .ctl_word_valid(ctl_word_valid), .data_req(data_req), .data_bytes(data_bytes), .data_grant(data_grant),
    .diag_bit33(diag_bit33), .diag_bit32(diag_bit32));
  peer_receiver rx (.sys_clk(sys_clk), .ctl_word_valid(ctl_word_valid), .ctl_word(ctl_word), .rx_cal(rx_cal),
    .rx_mu(rx_mu));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    // waitrequest and read data are sampled at the answer edge itself
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) fails++;
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk);
  endtask : bus
  task automatic req(input logic [6:0] b, input logic exp);
    logic g;
    g = 0;
    data_req <= 1;
    data_bytes <= b;
    for (int n = 0; n < 12 && !g; n++) begin @(negedge sys_clk); g = data_grant === 1'b1; @(posedge sys_clk); end
    data_req <= 0;
    chk(g, exp);
    @(posedge sys_clk);
  endtask : req
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    @(negedge sys_clk);
    chk(avs_waitrequest, 1'b1);
    @(posedge sys_clk);
    mu = 8'(xs());
    h = xs() & 32'h0001_0fff;
    bus(1, tx_cw_pkg::MULTI_USE_OFS, {24'h0, mu}, q);
    bus(1, tx_cw_pkg::HEALTH_OFS, h, q);
    @(negedge sys_clk);
    chk(diag_bit33, h[11:0]);
    chk(diag_bit32, {12{h[16]}});
    @(posedge sys_clk);
    bus(0, tx_cw_pkg::MULTI_USE_OFS, q, q);
    chk(q, {24'h0, mu});
    bus(0, 6'h3c, 32'h0, q);
    chk(q, 32'h0);
    $display("registers done");
    // path still off: words must flow anyway
    cal <= {8{xs()}};
    cw_slot <= 1;
    repeat (17) @(posedge sys_clk);
    cw_slot <= 0;
    repeat (2) @(posedge sys_clk);
    chk(rx_cal, cal);
    chk(rx_mu, mu);
    chk(ctl_word[56], 1'b1);
    // field unused from here on: user side holds it at zero
    bus(1, tx_cw_pkg::MULTI_USE_OFS, 32'h0, q);
    cw_slot <= 1;
    @(posedge sys_clk);
    cw_slot <= 0;
    repeat (2) @(posedge sys_clk);
    chk(ctl_word[31:24], 8'h00);
    $display("calendar done");
    req(7'd5, 0);
    bus(1, tx_cw_pkg::CTRL_OFS, 32'h1, q);
    req(7'd127, 1);
    bus(1, tx_cw_pkg::BUCKET_OFS, 32'd20, q);
    bus(1, tx_cw_pkg::CTRL_OFS, 32'h3, q);
    req(7'd20, 1);
    req(7'd1, 0);
    bus(1, tx_cw_pkg::BUCKET_OFS, 32'h0fff_0014, q);
    bus(0, tx_cw_pkg::STATUS_OFS, q, q);
    chk(q[11:0], 12'd20);
    req(7'd20, 1);
    $display("shaper done");
    stop_test();
  end
endmodule : tx_control_word_fields_tb
`default_nettype wire
